/* design/dtrmr_pkg.sv */
// ============================================================
// Overview of operation
// - dual read: BDh opcode, 24-bit address
// - dual: two bits each clock edge
// - dual dummy clocks configurable, default two
// - any start, increment per byte, wrap
// - chip select high ends read anytime
// - mode nibble A enters continuous read
// - other mode nibble leaves continuous read
// - reads rejected while write in progress
// - quad: four bits each clock edge
// - quad dummy clocks configurable, default three
// - quad command mode: opcode in two clocks
// - quad command mode ignores quad enable
// - busy flag shows internal write running
package dtrmr_pkg;
  // ============================================================
  // link encodings
  localparam int ADDR_W = 24; // flash byte address width
  localparam int MEM_AW = 12; // backing store index width
  localparam logic [7:0] OP_DUAL = 8'hBD; // dual_io_dtr_read
  localparam logic [7:0] OP_QUAD = 8'hED; // quad_io_dtr_read
  localparam logic [3:0] CRM_NIB = 4'hA; // continuous_read_mode pattern
  // ============================================================
  // phase lengths; the LAST values count serial clock edges less one
  localparam logic [4:0] CMD_LAST_SINGLE = 5'h07; // eight rising edges
  localparam logic [4:0] CMD_LAST_QUAD = 5'h01; // two rising edges
  localparam logic [4:0] ADDR_LAST_DUAL = 5'h0B; // twelve edges
  localparam logic [4:0] ADDR_LAST_QUAD = 5'h05; // six edges
  localparam logic [4:0] MODE_EDGES_DUAL = 5'h04; // mode byte edges
  localparam logic [4:0] MODE_EDGES_QUAD = 5'h02;
  localparam logic [3:0] DUMMY_DUAL_RST = 4'h2; // dummy clocks
  localparam logic [3:0] DUMMY_QUAD_RST = 4'h3;
  localparam logic [3:0] LANES_DUAL = 4'h3; // driven data lines
  localparam logic [3:0] LANES_QUAD = 4'hF;
  // ============================================================
  // register map
  localparam logic [7:0] REG_CFG = 8'h00;
  localparam logic [7:0] REG_BUSY = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_MEM_ADDR = 8'h0C;
  localparam logic [7:0] REG_MEM_DATA = 8'h10;
  localparam logic [7:0] REG_CUR_ADDR = 8'h14;
  localparam int CFG_QE_BIT = 0; // quad_enable_bit
  localparam int CFG_QCM_BIT = 1; // quad_command_mode
  localparam int CFG_DDUM_LSB = 4; // dual dummy clocks, 4 bits
  localparam int CFG_QDUM_LSB = 8; // quad dummy clocks, 4 bits
  localparam int ST_WIP_BIT = 0; // write_in_progress_flag
  localparam int ST_CRM_BIT = 1; // continuous read armed
  localparam int ST_CRMQ_BIT = 2; // armed read is quad
  localparam int ST_REJ_LSB = 8; // busy reject count, 8 bits
  // ============================================================
  // link state machine
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_CMD = 6'h02,
    ST_ADDR = 6'h04,
    ST_DUMMY = 6'h08,
    ST_DATA = 6'h10,
    ST_REJECT = 6'h20
  } dtrmr_state_t;
endpackage : dtrmr_pkg

/* design/dtrmr_sync.sv */
`timescale 1ns/1ps
// ============================================================
// two-stage synchroniser for pin inputs
module dtrmr_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk, // sampling clock
  input wire logic reset, // async reset, active high
  input wire logic [W-1:0] din, // asynchronous inputs
  output logic [W-1:0] dout // synchronised outputs
);
  logic [W-1:0] meta_reg; // first stage, read only by second stage

  // both stages reset to the idle level of the pins
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_reg <= RST_VAL;
      dout <= RST_VAL;
    end else begin
      meta_reg <= din;
      dout <= meta_reg;
    end
  end
endmodule : dtrmr_sync

/* design/dtrmr_mem.sv */
`timescale 1ns/1ps
// ============================================================
// byte store with one write port and a registered read port
module dtrmr_mem #(
  parameter int AW = 12,
  parameter int DW = 8
) (
  input wire logic clk, // store clock
  input wire logic we, // write strobe
  input wire logic [AW-1:0] waddr, // write index
  input wire logic [DW-1:0] wdata, // write byte
  input wire logic [AW-1:0] raddr, // read index
  output logic [DW-1:0] rdata // read byte, one cycle late
);
  logic [DW-1:0] store [0:(1<<AW)-1]; // array, no reset by design

  // write port
  always_ff @(posedge clk) begin
    if (we) begin
      store[waddr] <= wdata;
    end
  end

  // read port: always follows raddr one cycle later
  always_ff @(posedge clk) begin
    rdata <= store[raddr];
  end
endmodule : dtrmr_mem

/* design/dtrmr_read.sv */
`timescale 1ns/1ps
// ============================================================
// double-transfer-rate dual and quad read engine with apb access
module dtrmr_read
  import dtrmr_pkg::*;
(
  input wire logic sys_clk, // system clock, 250 MHz
  input wire logic reset, // async reset, active high
  input wire logic [7:0] paddr, // apb byte address
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data, registered
  output logic pready, // apb ready, always high
  output logic pslverr, // apb error on unmapped address
  input wire logic serialClk, // link clock from host
  input wire logic chipSelN, // chip select, active low
  input wire logic dataLine0In, // data line 0 sampled level
  input wire logic dataLine1In, // data line 1 sampled level
  input wire logic dataLine2In, // data line 2 sampled level
  input wire logic dataLine3In, // data line 3 sampled level
  output logic dataLine0Out, // data line 0 driven level
  output logic dataLine1Out, // data line 1 driven level
  output logic dataLine2Out, // data line 2 driven level
  output logic dataLine3Out, // data line 3 driven level
  output logic dataLine0Oe, // data line 0 drive enable
  output logic dataLine1Oe, // data line 1 drive enable
  output logic dataLine2Oe, // data line 2 drive enable
  output logic dataLine3Oe // data line 3 drive enable
);
  // ============================================================
  // pin synchronisation and edge detection
  logic [5:0] syncBus; // {cs, clk, data[3:0]} after two flops
  logic csS; // synced chip select, high = deselected
  logic clkS; // synced serial clock
  logic [3:0] din; // synced data lines
  logic clkPrev_reg; // last synced clock level
  logic rise; // serial clock rising edge seen
  logic fall; // serial clock falling edge seen
  logic edgeAny; // either edge

  // data and clock share one pipeline so they stay aligned
  dtrmr_sync #(.W(6), .RST_VAL(6'h20)) u_sync (
    .clk(sys_clk),
    .reset(reset),
    .din({chipSelN, serialClk, dataLine3In, dataLine2In, dataLine1In, dataLine0In}),
    .dout(syncBus)
  );

  assign csS = syncBus[5];
  assign clkS = syncBus[4];
  assign din = syncBus[3:0];
  assign rise = clkS & ~clkPrev_reg;
  assign fall = ~clkS & clkPrev_reg;
  assign edgeAny = rise | fall;

  // previous clock level for edge finding
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      clkPrev_reg <= 1'b0;
    end else begin
      clkPrev_reg <= clkS;
    end
  end

  // ============================================================
  // apb register file
  logic cfgQe_reg; // quad_enable_bit
  logic cfgQcm_reg; // quad_command_mode
  logic [3:0] cfgDualDum_reg; // dual dummy clocks
  logic [3:0] cfgQuadDum_reg; // quad dummy clocks
  logic [15:0] busyCnt_reg; // internal write cycles left
  logic [MEM_AW-1:0] memIdx_reg; // store load pointer
  logic [7:0] rejCnt_reg; // busy rejects, saturating
  logic apbSetup; // setup phase
  logic apbWr; // write access phase
  logic selCfg, selBusy, selStat, selMemA, selMemD, selCur;
  logic hit; // address maps to a register
  logic write_in_progress_flag; // write_in_progress_flag
  logic [31:0] rdMux; // read data selection
  logic crmReg_reg; // continuous_read_mode armed
  logic crmQuad_reg; // armed read kind
  logic [23:0] byteAddr_reg; // address of byte being sent

  assign apbSetup = psel & ~penable;
  assign apbWr = psel & penable & pwrite;
  assign selCfg = paddr == REG_CFG;
  assign selBusy = paddr == REG_BUSY;
  assign selStat = paddr == REG_STATUS;
  assign selMemA = paddr == REG_MEM_ADDR;
  assign selMemD = paddr == REG_MEM_DATA;
  assign selCur = paddr == REG_CUR_ADDR;
  assign hit = selCfg | selBusy | selStat | selMemA | selMemD | selCur;
  assign pready = 1'b1; // zero wait states
  assign pslverr = psel & penable & ~hit;
  assign write_in_progress_flag = busyCnt_reg != 16'h0000;

  assign rdMux =
    selCfg ? {20'h0_0000, cfgQuadDum_reg, cfgDualDum_reg, 2'b00, cfgQcm_reg, cfgQe_reg} :
    selBusy ? {16'h0000, busyCnt_reg} :
    selStat ? {16'h0000, rejCnt_reg, 5'h00, crmQuad_reg, crmReg_reg, write_in_progress_flag} :
    selMemA ? {{(32-MEM_AW){1'b0}}, memIdx_reg} :
    selCur ? {8'h00, byteAddr_reg} : 32'h0000_0000;

  // read data captured in setup so it is a flop in the access phase
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else if (apbSetup) begin
      prdata <= rdMux;
    end
  end

  // configuration, dummy counts come up at their documented defaults
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cfgQe_reg <= 1'b0;
      cfgQcm_reg <= 1'b0;
      cfgDualDum_reg <= DUMMY_DUAL_RST;
      cfgQuadDum_reg <= DUMMY_QUAD_RST;
    end else if (apbWr & selCfg) begin
      cfgQe_reg <= pwdata[CFG_QE_BIT];
      cfgQcm_reg <= pwdata[CFG_QCM_BIT];
      cfgDualDum_reg <= pwdata[CFG_DDUM_LSB +: 4];
      cfgQuadDum_reg <= pwdata[CFG_QDUM_LSB +: 4];
    end
  end

  // stands in for a program or erase: counts down, reads cannot stop it
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      busyCnt_reg <= 16'h0000;
    end else if (apbWr & selBusy) begin
      busyCnt_reg <= pwdata[15:0];
    end else if (write_in_progress_flag) begin
      busyCnt_reg <= busyCnt_reg - 16'h0001;
    end
  end

  // store load pointer, steps after each data write
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      memIdx_reg <= '0;
    end else if (apbWr & selMemA) begin
      memIdx_reg <= pwdata[MEM_AW-1:0];
    end else if (apbWr & selMemD) begin
      memIdx_reg <= memIdx_reg + MEM_AW'(1);
    end
  end

  // ============================================================
  // link phase decoding
  dtrmr_state_t state_reg, state_next; // link state
  logic [4:0] edgeCnt_reg; // edges within the phase
  logic [7:0] opSr_reg; // opcode shifter
  logic [23:0] addrSr_reg; // address shifter
  logic [7:0] modeSr_reg; // mode byte shifter
  logic quadReg_reg; // current read is four-line
  logic [3:0] out_reg; // driven data levels
  logic [3:0] oe_reg; // driven data enables
  logic [7:0] memRdata; // byte at byteAddr
  logic [7:0] opNext, modeNext, modeNow;
  logic [23:0] addrNext;
  logic [4:0] cmdLast, addrLast, dumLast, modeEdges;
  logic [3:0] dumClk, sliceOut, lanes;
  logic [1:0] dualSlice;
  logic cmdDone, acceptDual, acceptQuad, addrEdge, addrDone;
  logic dumEdge, dumDone, dataEdge, sliceLast;

  // opcode: one bit per rising edge, or a nibble in quad command mode
  assign opNext = cfgQcm_reg ? {opSr_reg[3:0], din} : {opSr_reg[6:0], din[0]};
  assign cmdLast = cfgQcm_reg ? CMD_LAST_QUAD : CMD_LAST_SINGLE;
  assign cmdDone = (state_reg == ST_CMD) & rise & (edgeCnt_reg == cmdLast);
  assign acceptDual = ~cfgQcm_reg & (opNext == OP_DUAL);
  // quad command mode takes EDh whatever the enable bit says
  assign acceptQuad = (opNext == OP_QUAD) & (cfgQcm_reg | cfgQe_reg);

  // address: both edges, a stray leading falling edge is skipped
  assign addrNext = quadReg_reg ? {addrSr_reg[19:0], din}
                                : {addrSr_reg[21:0], din[1:0]};
  assign addrEdge = (state_reg == ST_ADDR) & (rise | (fall & (edgeCnt_reg != 5'h00)));
  assign addrLast = quadReg_reg ? ADDR_LAST_QUAD : ADDR_LAST_DUAL;
  assign addrDone = addrEdge & (edgeCnt_reg == addrLast);

  // dummy: mode byte rides the first edges, a zero count acts as one clock
  assign dumClk = quadReg_reg ? cfgQuadDum_reg : cfgDualDum_reg;
  assign dumLast = (dumClk == 4'h0) ? 5'h01 : {dumClk, 1'b0} - 5'h01;
  assign modeEdges = quadReg_reg ? MODE_EDGES_QUAD : MODE_EDGES_DUAL;
  assign modeNext = quadReg_reg ? {modeSr_reg[3:0], din} : {modeSr_reg[5:0], din[1:0]};
  assign modeNow = (edgeCnt_reg < modeEdges) ? modeNext : modeSr_reg;
  assign dumEdge = (state_reg == ST_DUMMY) & edgeAny;
  assign dumDone = dumEdge & (edgeCnt_reg == dumLast);

  // data: msb first, one slice per edge
  assign dataEdge = (state_reg == ST_DATA) & edgeAny;
  assign sliceLast = quadReg_reg ? edgeCnt_reg[0] : (edgeCnt_reg[1:0] == 2'h3);
  assign dualSlice = 2'(memRdata >> {~edgeCnt_reg[1:0], 1'b0});
  assign sliceOut = quadReg_reg ? (edgeCnt_reg[0] ? memRdata[3:0] : memRdata[7:4])
                                : {2'b00, dualSlice};
  assign lanes = quadReg_reg ? LANES_QUAD : LANES_DUAL;

  // the store only aliases the low index bits of the 24-bit space
  dtrmr_mem #(.AW(MEM_AW), .DW(8)) u_mem (
    .clk(sys_clk),
    .we(apbWr & selMemD),
    .waddr(memIdx_reg),
    .wdata(pwdata[7:0]),
    .raddr(byteAddr_reg[MEM_AW-1:0]),
    .rdata(memRdata)
  );

  // ============================================================
  // link state machine
  always_comb begin
    state_next = state_reg;
    if (csS) begin
      state_next = ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          // armed continuous read skips the opcode
          if (!crmReg_reg) begin
            state_next = ST_CMD;
          end else begin
            state_next = write_in_progress_flag ? ST_REJECT : ST_ADDR;
          end
        end
        ST_CMD: begin
          // unknown opcodes and busy device both park until deselect
          if (cmdDone) begin
            state_next = (write_in_progress_flag | ~(acceptDual | acceptQuad)) ? ST_REJECT : ST_ADDR;
          end
        end
        ST_ADDR: begin
          if (addrDone) begin
            state_next = ST_DUMMY;
          end
        end
        ST_DUMMY: begin
          if (dumDone) begin
            state_next = ST_DATA;
          end
        end
        ST_DATA, ST_REJECT: state_next = state_reg; // held until deselect
        default: state_next = ST_IDLE;
      endcase
    end
  end

  // state and edge counter
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      edgeCnt_reg <= 5'h00;
    end else begin
      state_reg <= state_next;
      if (state_next != state_reg) begin
        edgeCnt_reg <= 5'h00;
      end else if (dataEdge) begin
        edgeCnt_reg <= sliceLast ? 5'h00 : edgeCnt_reg + 5'h01;
      end else if (((state_reg == ST_CMD) & rise) | addrEdge | dumEdge) begin
        edgeCnt_reg <= edgeCnt_reg + 5'h01;
      end
    end
  end

  // shifters for opcode, address and mode byte
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      opSr_reg <= 8'h00;
      addrSr_reg <= 24'h00_0000;
      modeSr_reg <= 8'h00;
    end else begin
      if ((state_reg == ST_CMD) & rise) opSr_reg <= opNext;
      if (addrEdge) addrSr_reg <= addrNext;
      if (dumEdge & (edgeCnt_reg < modeEdges)) modeSr_reg <= modeNext;
    end
  end

  // read kind: from the opcode, or remembered for continuous reads
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      quadReg_reg <= 1'b0;
    end else if ((state_reg == ST_IDLE) & ~csS & crmReg_reg) begin
      quadReg_reg <= crmQuad_reg;
    end else if (cmdDone) begin
      quadReg_reg <= acceptQuad;
    end
  end

  // continuous read decided once, at the end of the dummy phase
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      crmReg_reg <= 1'b0;
      crmQuad_reg <= 1'b0;
    end else if (dumDone) begin
      crmReg_reg <= modeNow[7:4] == CRM_NIB;
      crmQuad_reg <= quadReg_reg;
    end
  end

  // byte address: loaded from the link, steps per byte, 24-bit wrap
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      byteAddr_reg <= 24'h00_0000;
    end else if (addrDone) begin
      byteAddr_reg <= addrNext;
    end else if (dataEdge & sliceLast) begin
      byteAddr_reg <= byteAddr_reg + 24'h00_0001;
    end
  end

  // pin drive: only in the data phase, dropped with deselect
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      out_reg <= 4'h0;
      oe_reg <= 4'h0;
    end else if (state_next != ST_DATA) begin
      oe_reg <= 4'h0;
    end else if (dataEdge) begin
      out_reg <= sliceOut;
      oe_reg <= lanes;
    end
  end

  // busy rejects counted for software, saturating
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rejCnt_reg <= 8'h00;
    end else if ((state_next == ST_REJECT) & (state_reg != ST_REJECT) & write_in_progress_flag) begin
      if (rejCnt_reg != 8'hFF) rejCnt_reg <= rejCnt_reg + 8'h01;
    end
  end

  assign {dataLine3Out, dataLine2Out, dataLine1Out, dataLine0Out} = out_reg;
  assign {dataLine3Oe, dataLine2Oe, dataLine1Oe, dataLine0Oe} = oe_reg;

  // ============================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence s_dummy_last;
    dumDone;
  endsequence

  a_drive_in_data: assert property (oe_reg != 4'h0 |-> state_reg == ST_DATA)
    else $error("data lines driven outside data phase");
  a_data_after_dummy: assert property (s_dummy_last |=> state_reg == ST_DATA ##0 oe_reg == 4'h0)
    else $error("dummy end did not open data phase undriven");
  a_deselect_release: assert property ($rose(csS) |=> oe_reg == 4'h0 && state_reg == ST_IDLE)
    else $error("deselect did not release data lines");
  a_addr_step: assert property (dataEdge && sliceLast |=> byteAddr_reg == $past(byteAddr_reg) + 24'h00_0001)
    else $error("byte address did not step");
  a_crm_enter: assert property (s_dummy_last ##0 modeNow[7:4] == CRM_NIB |=> crmReg_reg)
    else $error("mode pattern did not arm continuous read");
  a_crm_leave: assert property (s_dummy_last ##0 modeNow[7:4] != CRM_NIB |=> !crmReg_reg)
    else $error("continuous read not left");
  a_busy_reject: assert property (cmdDone && write_in_progress_flag |=> state_reg == ST_REJECT ##1 oe_reg == 4'h0)
    else $error("read accepted while busy");
  a_dual_accept: assert property (cmdDone && !write_in_progress_flag && acceptDual |=> state_reg == ST_ADDR && !quadReg_reg)
    else $error("dual read not accepted");
  a_qcm_accept: assert property (cmdDone && !write_in_progress_flag && cfgQcm_reg && opNext == OP_QUAD |=> quadReg_reg)
    else $error("quad command mode read refused");
  a_lane_width: assert property (oe_reg != 4'h0 |-> oe_reg == (quadReg_reg ? LANES_QUAD : LANES_DUAL))
    else $error("wrong data lanes driven");
endmodule : dtrmr_read

/* dv/dtrmr_host.sv */
`timescale 1ns/1ps
// ============================================================
// host flash controller: select, link clock and data lines
module dtrmr_host (
  input wire logic sys_clk, // bench clock
  output logic serialClk, // link clock, still between frames
  output logic chipSelN, // select, active low
  input wire logic [3:0] devOut, // device driven levels
  input wire logic [3:0] devOe, // device drive enables
  output wire [3:0] lineIn // resolved line levels
);
  logic [3:0] hOut = 4'h0; // host driven levels
  logic [3:0] hOe = 4'h0; // host drive enables
  logic flt = 1'b0; // released lines toggle, so a stale value never matches
  logic dataPh = 1'b0; // data phase window
  logic sawOe = 1'b0; // device drove a line this frame
  logic early = 1'b0; // device drove outside the data phase
  assign lineIn = (devOe & devOut) | (~devOe & hOe & hOut) | (~devOe & ~hOe & {4{flt}});
  initial begin
    serialClk = 1'b0;
    chipSelN = 1'b1;
  end
  // ============================================================
  // watch the device's drive enables
  always @(posedge sys_clk) begin
    flt <= ~flt;
    if (|devOe) sawOe <= 1'b1;
    if (|devOe && !dataPh) early <= 1'b1;
  end
  // one link edge: data changes mid half-period, sample just before the edge
  task automatic ed(input logic [3:0] v, input logic [3:0] en, output logic [3:0] s);
    repeat (5) @(posedge sys_clk);
    hOut <= v;
    hOe <= en;
    repeat (4) @(posedge sys_clk);
    s = lineIn;
    @(posedge sys_clk);
    serialClk <= ~serialClk;
  endtask : ed
  // one whole read frame; rx holds the bytes read back
  task automatic xfer(input bit quad, input bit qcm, input bit sendOp, input logic [7:0] op,
      input logic [23:0] addr, input logic [7:0] mode, input int dum, input int nb,
      output logic [7:0] rx [4]);
    logic [3:0] s;
    logic [3:0] v;
    logic [3:0] en;
    logic [31:0] sh;
    int w;
    w = quad ? 4 : 2;
    en = quad ? 4'hF : 4'h3;
    sawOe = 1'b0;
    chipSelN <= 1'b0;
    if (sendOp) begin
      for (int i = 0; i < (qcm ? 2 : 8); i++) begin
        v = qcm ? op[7-4*i -: 4] : {3'b000, op[7-i]};
        repeat (2) ed(v, qcm ? 4'hF : 4'h1, s);
      end
    end
    sh = {addr, mode};
    for (int i = 0; i < 24 / w + 2 * dum; i++) begin
      v = quad ? sh[31:28] : {2'b00, sh[31:30]};
      ed(v, (i < 28 / w) ? en : 4'h0, s);
      sh = sh << w;
    end
    dataPh = 1'b1;
    sh = '0;
    for (int i = 0; i <= nb * 8 / w; i++) begin
      ed(4'h0, 4'h0, s);
      if (i > 0) sh = (sh << w) | {28'h0, s & en};
      if (i > 0 && (i * w) % 8 == 0) rx[i * w / 8 - 1] = sh[7:0];
    end
    @(posedge sys_clk);
    if (serialClk) ed(4'h0, 4'h0, s);
    repeat (5) @(posedge sys_clk);
    chipSelN <= 1'b1;
    repeat (30) @(posedge sys_clk);
    dataPh = 1'b0;
  endtask : xfer
endmodule : dtrmr_host

/* dv/tb_dtr_multi_io_flash_read.sv */
`timescale 1ns/1ps
// ============================================================
// bench: apb register access plus host read frames
module tb_dtr_multi_io_flash_read;
  import dtrmr_pkg::*;
  logic sys_clk = 1'b0; // 250 MHz
  logic reset = 1'b1; // async, active high
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire serialClk;
  wire chipSelN;
  wire [3:0] lineIn;
  wire [3:0] devOut;
  wire [3:0] devOe;
  int bad_count = 0;
  int n_compared = 0;
  logic [31:0] rd;
  logic err;
  logic [7:0] rx [4];
  always #2 sys_clk = ~sys_clk;
  dtrmr_read u_dtrmr_read (.sys_clk(sys_clk), .reset(reset), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serialClk(serialClk), .chipSelN(chipSelN),
    .dataLine0In(lineIn[0]), .dataLine1In(lineIn[1]), .dataLine2In(lineIn[2]),
    .dataLine3In(lineIn[3]), .dataLine0Out(devOut[0]), .dataLine1Out(devOut[1]),
    .dataLine2Out(devOut[2]), .dataLine3Out(devOut[3]), .dataLine0Oe(devOe[0]),
    .dataLine1Oe(devOe[1]), .dataLine2Oe(devOe[2]), .dataLine3Oe(devOe[3]));
  dtrmr_host u_dtrmr_host (.sys_clk(sys_clk), .serialClk(serialClk), .chipSelN(chipSelN),
    .devOut(devOut), .devOe(devOe), .lineIn(lineIn));
  // ============================================================
  // helpers
  function automatic logic [7:0] eb(input logic [11:0] x);
    return x[7:0] ^ 8'hA5; // store pattern, repeats every 256 indices
  endfunction : eb
  task automatic conclude();
    if (bad_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // one apb transfer; an idle cycle follows so psel is never set twice at one edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0000_0000);
    chk(nm, rd, e);
  endtask : rdc
  task automatic rxc(input string nm, input logic [11:0] a, input int nb);
    for (int i = 0; i < nb; i++) chk(nm, {24'h0, rx[i]}, {24'h0, eb(a + i[11:0])});
  endtask : rxc
  // ============================================================
  // main sequence
  initial begin
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rdc("cfg", REG_CFG, 32'h0000_0320);
    rdc("status", REG_STATUS, 32'h0000_0000);
    apb(8'h18, 1'b0, 32'h0000_0000);
    chk("unmapped", {31'h0, err}, 32'h0000_0001);
    apb(REG_MEM_ADDR, 1'b1, 32'h0000_0FFE);
    for (int i = 0; i < 10; i++) apb(REG_MEM_DATA, 1'b1, {24'h0, eb(12'hFFE + i[11:0])});
    u_dtrmr_host.xfer(0, 0, 1, OP_DUAL, 24'hFF_FFFE, 8'h00, 2, 4, rx);
    rxc("dual", 12'hFFE, 4);
    chk("oe", {28'h0, devOe}, 32'h0000_0000);
    rdc("cur", REG_CUR_ADDR, 32'h0000_0002);
    u_dtrmr_host.xfer(1, 0, 1, OP_QUAD, 24'h00_0000, 8'h00, 3, 1, rx);
    chk("noqe", {31'h0, u_dtrmr_host.sawOe}, 32'h0000_0000);
    apb(REG_CFG, 1'b1, 32'h0000_0321);
    u_dtrmr_host.xfer(1, 0, 1, OP_QUAD, 24'h00_0002, 8'hA5, 3, 3, rx);
    rxc("quad", 12'h002, 3);
    rdc("armed", REG_STATUS, 32'h0000_0006);
    u_dtrmr_host.xfer(1, 0, 0, 8'h00, 24'h00_0005, 8'h00, 3, 2, rx);
    rxc("cont", 12'h005, 2);
    rdc("disarm", REG_STATUS, 32'h0000_0004);
    apb(REG_BUSY, 1'b1, 32'h0000_05DC);
    rdc("wip", REG_STATUS, 32'h0000_0005);
    u_dtrmr_host.xfer(0, 0, 1, OP_DUAL, 24'h00_0000, 8'h00, 2, 1, rx);
    chk("busyrd", {31'h0, u_dtrmr_host.sawOe}, 32'h0000_0000);
    apb(REG_BUSY, 1'b0, 32'h0000_0000);
    chk("busyrun", {31'h0, rd > 0 && rd < 32'h0000_05DC}, 32'h0000_0001);
    rdc("reject", REG_STATUS, 32'h0000_0105);
    for (int i = 0; i < 500 && rd[0] !== 1'b0; i++) apb(REG_STATUS, 1'b0, 32'h0000_0000);
    chk("done", rd, 32'h0000_0104);
    apb(REG_CFG, 1'b1, 32'h0000_0422);
    u_dtrmr_host.xfer(1, 1, 1, OP_QUAD, 24'h00_0000, 8'h00, 4, 2, rx);
    rxc("qcm", 12'h000, 2);
    chk("early", {31'h0, u_dtrmr_host.early}, 32'h0000_0000);
    conclude();
  end
endmodule : tb_dtr_multi_io_flash_read
